// File: cell_monitor_regs.svh
// Register offsets, field positions and reset values of the cell monitor.
// Assumes a 32-bit bus; each six-byte group spans two aligned words.
`ifndef CELL_MONITOR_REGS_SVH
`define CELL_MONITOR_REGS_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define CM_ADDR_W 7
`define CM_GRP_CFG 4'h0
`define CM_GRP_CELL_C 4'h3
`define CM_GRP_LAST_RES 4'h7
`define CM_GRP_STAT_B 4'h8
`define CM_GRP_COMM 4'h9
`define CM_CFG_W0_OFS 7'h00
`define CM_CFG_W1_OFS 7'h04
`define CM_COMM_W0_OFS 7'h48
`define CM_COMM_W1_OFS 7'h4c
`define CM_IRQ_STAT_OFS 7'h50
`define CM_IRQ_MASK_OFS 7'h54

// ----------------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------------
`define CM_PIN_MSB 7
`define CM_PIN_LSB 3
`define CM_BIAS_BIT 2
`define CM_TMR_PIN_BIT 1
`define CM_ALT_BIT 0
`define CM_UV_MSB 19
`define CM_UV_LSB 8
`define CM_OV_MSB 31
`define CM_OV_LSB 20
`define CM_DSEL_MSB 43
`define CM_DSEL_LSB 32
`define CM_DTO_MSB 47
`define CM_DTO_LSB 44
`define CM_CFG_RESET 48'h0000_0000_00f8
`define CM_COMM_RESET 48'h0000_0000_0000

// ----------------------------------------------------------------------
// Result slots and interrupt bits
// ----------------------------------------------------------------------
`define CM_NUM_CELLS 12
`define CM_NUM_SLOTS 23
`define CM_SLOT_CELL8 5'h07
`define CM_SLOT_DIG 5'h15
`define CM_SLOT_C7_ALT 5'h16
`define CM_IRQ_W 5
`define CM_IRQ_UV 0
`define CM_IRQ_OV 1
`define CM_IRQ_HOT 2
`define CM_IRQ_MUX 3
`define CM_IRQ_OVL 4

`endif

// File: cell_monitor_pkg.sv
// Types shared by the cell monitor register block.
// Assumes the constants header is on the include path.
`include "cell_monitor_regs.svh"

package cell_monitor_pkg;

   // ----------------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic hsel;
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_s;

   typedef struct packed {
      logic hreadyout;
      logic [31:0] hrdata;
      logic hresp;
   } ahb_rsp_s;

   typedef struct packed {
      logic wr;
      logic [`CM_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } reg_acc_s;

   // ----------------------------------------------------------------------
   // Measurement side carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [4:0] slot;
      logic [15:0] value;
   } result_wr_s;

   typedef struct packed {
      logic valid;
      logic [1:0] rate_field;
   } conv_cmd_s;

   typedef struct packed {
      logic valid;
      logic [1:0] slot;
      logic [7:0] data;
   } comm_rx_s;

   typedef struct packed {
      logic [3:0] lead_in_code;
      logic [7:0] data;
      logic [3:0] trailer_code;
   } xfer_slot_s;

   typedef enum logic [2:0] {
      RATE_27K, RATE_14K, RATE_7K, RATE_3K, RATE_2K, RATE_1K, RATE_422, RATE_26
   } rate_mode_e;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRITE = 3'b010,
      BUS_READ = 3'b100
   } bus_state_e;

   // ----------------------------------------------------------------------
   // Module state records
   // ----------------------------------------------------------------------
   typedef struct packed {
      bus_state_e state;
      logic hready;
      logic [31:0] hrdata;
      logic [`CM_ADDR_W-1:0] addr;
   } front_state_s;

   typedef struct packed {
      logic [47:0] cfg;
      logic [47:0] comm;
      logic [`CM_NUM_SLOTS-1:0][15:0] res;
      logic [`CM_NUM_CELLS-1:0] uv;
      logic [`CM_NUM_CELLS-1:0] ov;
      logic ovl_active;
      logic overheat;
      logic mux_fault;
      logic [`CM_IRQ_W-1:0] irq_stat;
      logic [`CM_IRQ_W-1:0] irq_mask;
      logic irq;
      logic [4:0] pulldown_en;
      rate_mode_e rate;
      logic bias_on;
   } monitor_state_s;

endpackage

// File: pin_sync.sv
// Three-stage synchroniser for pin levels with an agreement filter.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/10ps

module pin_sync
   #(parameter int W = 6)
   (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
   );

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } sync_state_s;

   sync_state_s q;
   sync_state_s n;

   // Shift chain; level follows only when stages two and three agree
   always_comb begin
      n = q;
      n.s1 = pin_i;
      n.s2 = q.s1;
      n.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            n.level[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign level_o = q.level;

endmodule

// File: ahb_reg_front.sv
// AHB-Lite slave front end: write strobes and one-wait-state reads.
// Assumes single word transfers; response is always OKAY.
`timescale 1ns/10ps
`include "cell_monitor_regs.svh"

module ahb_reg_front
   import cell_monitor_pkg::*;
   (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire ahb_req_s ahb_i,
   output ahb_rsp_s ahb_o,
   output reg_acc_s acc_o,
   input wire logic [31:0] rdata_i
   );

   front_state_s q;
   front_state_s n;
   logic take;

   // Address phase capture and data phase sequencing
   always_comb begin
      n = q;
      take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
      unique case (q.state)
         BUS_IDLE: begin
            n.state = BUS_IDLE;
         end
         BUS_WRITE: begin
            n.state = BUS_IDLE;
         end
         BUS_READ: begin
            n.hrdata = rdata_i;
            n.hready = 1'b1;
            n.state = BUS_IDLE;
         end
      endcase
      if (take && q.state != BUS_READ) begin
         n.addr = ahb_i.haddr[`CM_ADDR_W-1:0];
         n.state = ahb_i.hwrite ? BUS_WRITE : BUS_READ;
         n.hready = ahb_i.hwrite;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '{state: BUS_IDLE, hready: 1'b1, hrdata: 32'h0000_0000, addr: '0};
      end else begin
         q <= n;
      end
   end

   // Write lands at the edge that ends the zero-wait data phase
   assign acc_o.wr = (q.state == BUS_WRITE);
   assign acc_o.addr = q.addr;
   assign acc_o.wdata = ahb_i.hwdata;
   assign ahb_o.hreadyout = q.hready;
   assign ahb_o.hrdata = q.hrdata;
   assign ahb_o.hresp = 1'b0;

endmodule

// File: cell_monitor_regs.sv
// Register bank of a twelve-cell stack monitor behind an AHB-Lite port.
// Assumes results, commands and flags arrive from logic on clk_i;
// pin levels arrive asynchronously and are synchronised here.
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "cell_monitor_regs.svh"

module cell_monitor_regs
   import cell_monitor_pkg::*;
   #(parameter logic [3:0] DIE_VERSION = 4'h1) // Value is arbitrary
   (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire ahb_req_s ahb_i,
   output ahb_rsp_s ahb_o,
   input wire result_wr_s result_i,
   input wire conv_cmd_s conv_cmd_i,
   input wire logic overlap_done_i,
   input wire logic conv_busy_i,
   input wire logic watchdog_expired_i,
   input wire logic thermal_shutdown_i,
   input wire logic selector_fault_i,
   input wire comm_rx_s comm_rx_i,
   input wire logic [4:0] gp_pin_i,
   input wire logic discharge_timer_pin_i,
   output logic [4:0] pulldown_en_o,
   output logic [`CM_NUM_CELLS-1:0] discharge_select_o,
   output logic [3:0] discharge_timeout_o,
   output logic bias_on_o,
   output rate_mode_e rate_mode_o,
   output xfer_slot_s [2:0] xfer_slots_o,
   output logic irq_o
   );

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   monitor_state_s q;
   monitor_state_s n;
   reg_acc_s acc;
   logic [31:0] rdata;
   logic [5:0] pin_level;
   logic [2*`CM_NUM_CELLS-1:0] flag_bits;

   // Rate field decode under the option bit
   function automatic rate_mode_e rate_decode(input logic alt, input logic [1:0] field);
      rate_mode_e m;
      m = RATE_7K;
      unique case ({alt, field})
         3'b000: m = RATE_422;
         3'b001: m = RATE_27K;
         3'b010: m = RATE_7K;
         3'b011: m = RATE_26;
         3'b100: m = RATE_1K;
         3'b101: m = RATE_14K;
         3'b110: m = RATE_3K;
         3'b111: m = RATE_2K;
      endcase
      return m;
   endfunction

   // Word half of a six-byte group; upper half-word of the second reads zero
   function automatic logic [31:0] group_word(input logic [47:0] g, input logic hi);
      return hi ? {16'h0000, g[47:32]} : g[31:0];
   endfunction

   // ----------------------------------------------------------------------
   // Bus front end and pin synchronisers
   // ----------------------------------------------------------------------
   ahb_reg_front u_front (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ahb_i(ahb_i),
      .ahb_o(ahb_o),
      .acc_o(acc),
      .rdata_i(rdata)
   );

   pin_sync #(.W(6)) u_pins (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i({gp_pin_i, discharge_timer_pin_i}),
      .level_o(pin_level)
   );

   // ----------------------------------------------------------------------
   // Threshold flag interleave and transfer slot unpacking
   // ----------------------------------------------------------------------
   generate
      for (genvar i = 0; i < `CM_NUM_CELLS; i++) begin : g_flags
         assign flag_bits[2*i] = q.uv[i];
         assign flag_bits[2*i+1] = q.ov[i];
      end
      for (genvar s = 0; s < 3; s++) begin : g_slots
         assign xfer_slots_o[s].lead_in_code = q.comm[16*s+4 +: 4];
         assign xfer_slots_o[s].data = {q.comm[16*s +: 4], q.comm[16*s+12 +: 4]};
         assign xfer_slots_o[s].trailer_code = q.comm[16*s+8 +: 4];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------
   // Whole group assembled, then the addressed word picked out
   always_comb begin
      logic [3:0] grp;
      logic [4:0] s0;
      logic [47:0] g;
      grp = acc.addr[6:3];
      s0 = 5'h00;
      g = 48'h0000_0000_0000;
      rdata = 32'h0000_0000;
      if (grp == `CM_GRP_CFG) begin
         g = q.cfg;
         g[`CM_PIN_MSB:`CM_PIN_LSB] = pin_level[5:1];
         g[`CM_TMR_PIN_BIT] = pin_level[0];
         rdata = group_word(g, acc.addr[2]);
      end else if (grp <= `CM_GRP_LAST_RES) begin
         s0 = (5'(grp) - 5'h01) * 5'h03; // Widened before the product
         g = {q.res[s0+5'h02], q.res[s0+5'h01], q.res[s0]};
         if (grp == `CM_GRP_CELL_C && q.ovl_active) begin
            g[31:16] = q.res[`CM_SLOT_C7_ALT];
         end
         rdata = group_word(g, acc.addr[2]);
      end else if (grp == `CM_GRP_STAT_B) begin
         g = {DIE_VERSION, 2'b00, q.mux_fault, q.overheat, flag_bits, q.res[`CM_SLOT_DIG]};
         rdata = group_word(g, acc.addr[2]);
      end else if (grp == `CM_GRP_COMM) begin
         rdata = group_word(q.comm, acc.addr[2]);
      end else if (acc.addr == `CM_IRQ_STAT_OFS) begin
         rdata = {27'h000_0000, q.irq_stat};
      end else if (acc.addr == `CM_IRQ_MASK_OFS) begin
         rdata = {27'h000_0000, q.irq_mask};
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [`CM_IRQ_W-1:0] ev;
      logic [`CM_IRQ_W-1:0] clr;
      logic [15:0] uv_lim;
      logic [15:0] ov_lim;
      logic uv_now;
      logic ov_now;
      ev = '0;
      clr = '0;
      uv_now = 1'b0;
      ov_now = 1'b0;
      uv_lim = {q.cfg[`CM_UV_MSB:`CM_UV_LSB], 4'h0};
      ov_lim = {q.cfg[`CM_OV_MSB:`CM_OV_LSB], 4'h0};
      n = q;

      // Software writes; read-only groups and unmapped words ignore them
      if (acc.wr) begin
         unique case (acc.addr)
            `CM_CFG_W0_OFS: begin
               n.cfg[31:0] = {acc.wdata[31:2], 1'b0, acc.wdata[0]};
            end
            `CM_CFG_W1_OFS: begin
               n.cfg[47:32] = acc.wdata[15:0];
            end
            `CM_COMM_W0_OFS: begin
               n.comm[31:0] = acc.wdata;
            end
            `CM_COMM_W1_OFS: begin
               n.comm[47:32] = acc.wdata[15:0];
            end
            `CM_IRQ_STAT_OFS: begin
               clr = acc.wdata[`CM_IRQ_W-1:0];
            end
            `CM_IRQ_MASK_OFS: begin
               n.irq_mask = acc.wdata[`CM_IRQ_W-1:0];
            end
            default: begin
               n.irq_mask = q.irq_mask;
            end
         endcase
      end

      // Watchdog expiry drops the keep-bias request
      if (watchdog_expired_i) begin
         n.cfg[`CM_BIAS_BIT] = 1'b0;
      end

      // Serial master writes back received bytes over the data field
      if (comm_rx_i.valid && comm_rx_i.slot != 2'b11) begin
         n.comm[16*comm_rx_i.slot +: 4] = comm_rx_i.data[7:4];
         n.comm[16*comm_rx_i.slot+12 +: 4] = comm_rx_i.data[3:0];
      end

      // Result capture and per-cell threshold compare
      if (result_i.valid && result_i.slot < 5'(`CM_NUM_SLOTS)) begin
         n.res[result_i.slot] = result_i.value;
         if (result_i.slot < 5'(`CM_NUM_CELLS)) begin
            uv_now = result_i.value < uv_lim;
            ov_now = result_i.value > ov_lim;
            n.uv[result_i.slot[3:0]] = uv_now;
            n.ov[result_i.slot[3:0]] = ov_now;
            ev[`CM_IRQ_UV] = uv_now & ~q.uv[result_i.slot[3:0]];
            ev[`CM_IRQ_OV] = ov_now & ~q.ov[result_i.slot[3:0]];
         end
         if (result_i.slot == `CM_SLOT_CELL8) begin
            n.ovl_active = 1'b0;
         end
      end

      // Overlap check completion swaps in the alternate cell 7 result
      if (overlap_done_i) begin
         n.ovl_active = 1'b1;
         ev[`CM_IRQ_OVL] = 1'b1;
      end

      // Fault levels and their rising edges
      n.overheat = thermal_shutdown_i;
      n.mux_fault = selector_fault_i;
      ev[`CM_IRQ_HOT] = thermal_shutdown_i & ~q.overheat;
      ev[`CM_IRQ_MUX] = selector_fault_i & ~q.mux_fault;

      // Conversion rate follows the option bit at command time
      if (conv_cmd_i.valid) begin
         n.rate = rate_decode(q.cfg[`CM_ALT_BIT], conv_cmd_i.rate_field);
      end

      // Reference power: kept on request, else only while converting
      n.bias_on = conv_busy_i | n.cfg[`CM_BIAS_BIT];

      // Sticky status, set beats clear
      n.irq_stat = (q.irq_stat & ~clr) | ev;
      n.irq = |(n.irq_stat & n.irq_mask);

      // Pull-down drive is the inverse of the written control bit
      n.pulldown_en = ~n.cfg[`CM_PIN_MSB:`CM_PIN_LSB];
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '{cfg: `CM_CFG_RESET, comm: `CM_COMM_RESET, res: '0, uv: '0, ov: '0,
                ovl_active: 1'b0, overheat: 1'b0, mux_fault: 1'b0, irq_stat: '0,
                irq_mask: '0, irq: 1'b0, pulldown_en: 5'h00, rate: RATE_7K,
                bias_on: 1'b0};
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign pulldown_en_o = q.pulldown_en;
   assign discharge_select_o = q.cfg[`CM_DSEL_MSB:`CM_DSEL_LSB];
   assign discharge_timeout_o = q.cfg[`CM_DTO_MSB:`CM_DTO_LSB];
   assign bias_on_o = q.bias_on;
   assign rate_mode_o = q.rate;
   assign irq_o = q.irq;

endmodule

// File: cell_monitor_regs_properties.sv
// Concurrent checks on the ports of the cell monitor register block.
// Assumes one clock domain and a host that spaces its transfers.
`timescale 1ns/10ps

module cell_monitor_regs_properties
   import cell_monitor_pkg::*;
   (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire ahb_req_s ahb_i,
   input wire ahb_rsp_s ahb_o,
   input wire logic conv_busy_i,
   input wire logic [4:0] pulldown_en_o,
   input wire logic [11:0] discharge_select_o,
   input wire logic [3:0] discharge_timeout_o,
   input wire logic bias_on_o,
   input wire xfer_slot_s [2:0] xfer_slots_o,
   input wire logic irq_o
   );
   // ----------------------------------------------------------------------
   // Write data phase tracking
   // ----------------------------------------------------------------------
   logic wr_ph_q;
   logic [6:0] wa_q;
   logic [31:0] wd_q;
   // Flag a write data phase and keep the word it carried
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ph_q <= 1'b0;
         wa_q <= 7'h00;
         wd_q <= 32'h0000_0000;
      end else begin
         wr_ph_q <= ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready && ahb_i.hwrite;
         wa_q <= ahb_i.haddr[6:0];
         if (wr_ph_q) begin
            wd_q <= ahb_i.hwdata;
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence read_taken;
      ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready && !ahb_i.hwrite;
   endsequence
   sequence one_wait;
      !ahb_o.hreadyout ##1 ahb_o.hreadyout;
   endsequence
   read_wait_a: assert property (read_taken |=> one_wait)
      else $error("read without exactly one wait state");
   write_nowait_a: assert property (wr_ph_q |-> ahb_o.hreadyout)
      else $error("write was stalled");
   resp_okay_a: assert property (ahb_o.hresp == 1'b0)
      else $error("error response seen");
   rdata_hold_a: assert property (!$rose(ahb_o.hreadyout) |-> $stable(ahb_o.hrdata))
      else $error("read data moved outside a read");
   pulldown_map_a: assert property (wr_ph_q && wa_q == 7'h00 |=> ##[0:1]
      pulldown_en_o == ~wd_q[7:3]) else $error("pull-down enables wrong");
   discharge_map_a: assert property (wr_ph_q && wa_q == 7'h04 |=> ##[0:1]
      {discharge_timeout_o, discharge_select_o} == wd_q[15:0])
      else $error("discharge outputs wrong");
   xfer_map_a: assert property (wr_ph_q && wa_q == 7'h48 |=> ##[0:1]
      xfer_slots_o[0] == {wd_q[7:4], wd_q[3:0], wd_q[15:12], wd_q[11:8]})
      else $error("transfer slot wrong");
   bias_follow_a: assert property (conv_busy_i |=> bias_on_o)
      else $error("bias off during conversion");
   irq_drop_a: assert property ($fell(irq_o) |-> $past(wr_ph_q))
      else $error("interrupt dropped without a write");
endmodule

bind cell_monitor_regs cell_monitor_regs_properties chk (
   .clk_i(clk_i),
   .sys_rst_i(sys_rst_i),
   .ahb_i(ahb_i),
   .ahb_o(ahb_o),
   .conv_busy_i(conv_busy_i),
   .pulldown_en_o(pulldown_en_o),
   .discharge_select_o(discharge_select_o),
   .discharge_timeout_o(discharge_timeout_o),
   .bias_on_o(bias_on_o),
   .xfer_slots_o(xfer_slots_o),
   .irq_o(irq_o)
);

// File: ahb_host.sv
// Host model issuing single word AHB-Lite transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps

module ahb_host
   import cell_monitor_pkg::*;
   (
   input wire logic clk_i,
   input wire ahb_rsp_s rsp_i,
   output ahb_req_s req_o
   );
   ahb_req_s req_q;
   // Bus hready is the slave's hreadyout
   always_comb begin
      req_o = req_q;
      req_o.hready = rsp_i.hreadyout;
   end
   initial begin
      req_q = '0;
      req_q.hsel = 1'b1;
      req_q.hsize = 3'b010;
   end
   // Whole word only; phases held until hready is seen high
   task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      req_q.htrans <= 2'b10;
      req_q.haddr <= {25'h0, a};
      req_q.hwrite <= w;
      do @(posedge clk_i); while (rsp_i.hreadyout !== 1'b1);
      req_q.htrans <= 2'b00;
      req_q.hwdata <= d;
      do @(posedge clk_i); while (rsp_i.hreadyout !== 1'b1);
      q = rsp_i.hrdata;
   endtask
endmodule

// File: tb.sv
// Self-checking bench of the cell monitor register block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
   end \
end

module tb;
   import cell_monitor_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   ahb_req_s ahb_i;
   ahb_rsp_s ahb_o;
   result_wr_s result_i = '0;
   conv_cmd_s conv_cmd_i = '0;
   logic overlap_done_i = 1'b0;
   logic conv_busy_i = 1'b0;
   logic watchdog_expired_i = 1'b0;
   logic thermal_shutdown_i = 1'b0;
   logic selector_fault_i = 1'b0;
   comm_rx_s comm_rx_i = '0;
   logic [4:0] gp_pin_i = 5'h0d;
   logic discharge_timer_pin_i = 1'b0;
   logic [4:0] pulldown_en_o;
   logic [11:0] discharge_select_o;
   logic [3:0] discharge_timeout_o;
   logic bias_on_o;
   rate_mode_e rate_mode_o;
   xfer_slot_s [2:0] xfer_slots_o;
   logic irq_o;
   logic [31:0] q;
   logic [23:0] fl;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #4 clk_i = ~clk_i;

   cell_monitor_regs DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ahb_i(ahb_i), .ahb_o(ahb_o),
      .result_i(result_i), .conv_cmd_i(conv_cmd_i), .overlap_done_i(overlap_done_i),
      .conv_busy_i(conv_busy_i), .watchdog_expired_i(watchdog_expired_i),
      .thermal_shutdown_i(thermal_shutdown_i), .selector_fault_i(selector_fault_i),
      .comm_rx_i(comm_rx_i), .gp_pin_i(gp_pin_i), .discharge_timer_pin_i(discharge_timer_pin_i),
      .pulldown_en_o(pulldown_en_o), .discharge_select_o(discharge_select_o),
      .discharge_timeout_o(discharge_timeout_o), .bias_on_o(bias_on_o),
      .rate_mode_o(rate_mode_o), .xfer_slots_o(xfer_slots_o), .irq_o(irq_o));
   ahb_host host (.clk_i(clk_i), .rsp_i(ahb_o), .req_o(ahb_i));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic rd(input logic [6:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0000_0000, q);
      `CHECK($sformatf("word %h", a), e, q)
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   function automatic logic [15:0] rv(input int s);
      return 16'h1d2b * 16'(s + 1);
   endfunction
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_cfg();
      tick(6);
      `CHECK("pulldown", 5'h00, pulldown_en_o)
      `CHECK("rate", RATE_7K, rate_mode_o)
      rd(7'h00, 32'h0000_0068);
      wr(7'h00, 32'h9e15_c3a7);
      tick(2);
      `CHECK("pulldown", 5'h0b, pulldown_en_o)
      rd(7'h00, 32'h9e15_c36d);
      wr(7'h04, 32'hffff_7a5c);
      tick(2);
      `CHECK("dsel", 12'ha5c, discharge_select_o)
      `CHECK("dto", 4'h7, discharge_timeout_o)
      rd(7'h04, 32'h0000_7a5c);
      gp_pin_i <= 5'h12;
      discharge_timer_pin_i <= 1'b1;
      tick(5);
      rd(7'h00, 32'h9e15_c397);
      gp_pin_i <= 5'h0d;
      discharge_timer_pin_i <= 1'b0;
   endtask
   task automatic t_rate_bias();
      rate_mode_e ex [8] = '{RATE_422, RATE_27K, RATE_7K, RATE_26,
                             RATE_1K, RATE_14K, RATE_3K, RATE_2K};
      for (int i = 0; i < 8; i++) begin
         wr(7'h00, {24'h9e_15c3, 7'b101_0010, i[2]});
         @(posedge clk_i);
         conv_cmd_i <= '{1'b1, i[1:0]};
         @(posedge clk_i);
         conv_cmd_i.valid <= 1'b0;
         tick(1);
         `CHECK("rate", ex[i], rate_mode_o)
      end
      `CHECK("bias", 1'b1, bias_on_o)
      @(posedge clk_i);
      watchdog_expired_i <= 1'b1;
      @(posedge clk_i);
      watchdog_expired_i <= 1'b0;
      tick(3);
      `CHECK("bias", 1'b0, bias_on_o)
      rd(7'h00, 32'h9e15_c369);
      @(posedge clk_i);
      conv_busy_i <= 1'b1;
      tick(3);
      `CHECK("bias", 1'b1, bias_on_o)
      @(posedge clk_i);
      conv_busy_i <= 1'b0;
      tick(3);
      `CHECK("bias", 1'b0, bias_on_o)
   endtask
   task automatic t_results();
      for (int s = 0; s < 22; s++) begin
         @(posedge clk_i);
         result_i <= '{1'b1, 5'(s), rv(s)};
         @(posedge clk_i);
         result_i.valid <= 1'b0;
      end
      for (int g = 1; g < 8; g++) begin
         rd(7'(8 * g), {rv(3 * g - 2), rv(3 * g - 3)});
         rd(7'(8 * g + 4), {16'h0000, rv(3 * g - 1)});
      end
      for (int c = 0; c < 12; c++) begin
         fl[2 * c] = rv(c) < 16'h5c30;
         fl[2 * c + 1] = rv(c) > 16'h9e10;
      end
      rd(7'h40, {fl[15:0], rv(21)});
      rd(7'h44, {16'h0000, 8'h10, fl[23:16]});
      @(posedge clk_i);
      result_i <= '{1'b1, 5'd22, 16'h0abc};
      @(posedge clk_i);
      result_i.valid <= 1'b0;
      overlap_done_i <= 1'b1;
      @(posedge clk_i);
      overlap_done_i <= 1'b0;
      rd(7'h18, {16'h0abc, rv(6)});
      @(posedge clk_i);
      result_i <= '{1'b1, 5'd7, rv(7)};
      @(posedge clk_i);
      result_i.valid <= 1'b0;
      rd(7'h18, {rv(7), rv(6)});
      wr(7'h08, 32'hffff_ffff);
      rd(7'h08, {rv(1), rv(0)});
      wr(7'h60, 32'hffff_ffff);
      rd(7'h60, 32'h0000_0000);
   endtask
   task automatic t_irq();
      wr(7'h50, 32'h0000_001f);
      wr(7'h54, 32'h0000_0004);
      rd(7'h50, 32'h0000_0000);
      @(posedge clk_i);
      selector_fault_i <= 1'b1;
      tick(3);
      `CHECK("irq", 1'b0, irq_o)
      @(posedge clk_i);
      thermal_shutdown_i <= 1'b1;
      tick(3);
      `CHECK("irq", 1'b1, irq_o)
      rd(7'h50, 32'h0000_000c);
      rd(7'h44, {16'h0000, 8'h13, fl[23:16]});
      wr(7'h50, 32'h0000_0004);
      tick(1);
      `CHECK("irq", 1'b0, irq_o)
      rd(7'h50, 32'h0000_0008);
   endtask
   task automatic t_xfer();
      wr(7'h48, 32'h1234_5678);
      wr(7'h4c, 32'hffff_9abc);
      rd(7'h4c, 32'h0000_9abc);
      `CHECK("slot0", 16'h7856, xfer_slots_o[0])
      `CHECK("slot2", 16'hbc9a, xfer_slots_o[2])
      @(posedge clk_i);
      comm_rx_i <= '{1'b1, 2'd1, 8'h3e};
      @(posedge clk_i);
      comm_rx_i.valid <= 1'b0;
      rd(7'h48, 32'he233_5678);
   endtask

   // Cut a hung run short
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_cfg();
      t_rate_bias();
      t_results();
      t_irq();
      t_xfer();
      stop_test();
   end
endmodule
